// >>> core/mfilt_pkg.sv
/*
  Package for the motion input filter and shared interrupt flag block.
  Assumes a single 125 MHz system clock and a classic Wishbone register bus.
*/
// Behaviour
// - Output follows after three stable sample ticks.
// - Four filters: index, phase A, B, timer clock.
// - Per-filter enable; cleared bit routes raw input.
// - One shared sample strobe from instruction clock.
// - Divider codes give 1,2,4,16,32,64,128; 111 unused.
// - Reset clears filter control register entirely.
// - Capture mode: capture events set channel flags.
// - Encoder mode: velocity, position, direction flags.
// - Sleep stops capture; prescaler keeps counting events.
// - Sleep capture sets flag, wakes, buffer loads timer.
// - Encoder functions halt during sleep.
package mfilt_pkg;
  localparam logic [3:0] ADR_FILTER_CTRL = 4'h0;
  localparam logic [3:0] ADR_IRQ_FLAGS   = 4'h4;
  localparam logic [3:0] ADR_IRQ_ENABLE  = 4'h8;
  localparam logic [3:0] ADR_IRQ_CLEAR   = 4'hc;
  localparam logic [3:0] ADR_IRQ_PRIO    = 4'h4 + 4'h6;
  localparam logic [3:0] ADR_MODE        = 4'h4 + 4'h4 + 4'h4 + 4'h2;
  localparam logic [7:0] FILTER_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_RST         = 8'h00;
  localparam logic [7:0] FILTER_CTRL_MSK = 8'h7f;
  localparam logic [7:0] IRQ_MSK         = 8'h07;
  localparam int         DIV_LSB         = 0;
  localparam int         EN_LSB          = 3;
  localparam int         FLAG_VEL        = 0;
  localparam int         FLAG_POS        = 1;
  localparam int         FLAG_DIR        = 2;
  localparam logic [1:0] STABLE_TICKS    = 2'h3;
  localparam logic [2:0] DIV_UNUSED      = 3'h7;
  localparam logic [7:0] TIMER_RST       = 8'h00;
  localparam logic [6:0] DIV_LIM_1       = 7'h00;
  localparam logic [6:0] DIV_LIM_2       = 7'h01;
  localparam logic [6:0] DIV_LIM_4       = 7'h03;
  localparam logic [6:0] DIV_LIM_16      = 7'h0f;
  localparam logic [6:0] DIV_LIM_32      = 7'h1f;
  localparam logic [6:0] DIV_LIM_64      = 7'h3f;
  localparam logic [6:0] DIV_LIM_128     = 7'h7f;

  typedef struct packed {
    logic       timer_clock_filter_enable;
    logic       phase_b_filter_enable;
    logic       phase_a_filter_enable;
    logic       index_filter_enable;
    logic [2:0] filter_sample_divider;
  } mfilt_ctrl_s;

  typedef struct packed {
    logic       motion_timer_ext_clock;
    logic       encoder_phase_b;
    logic       encoder_phase_a;
    logic       encoder_index_input;
  } mfilt_pins_s;
endpackage

// >>> core/mfilt_top.sv
/*
  Four input noise filters, shared sample divider and the three shared
  motion interrupt flags behind a classic Wishbone slave.
  Assumes capture and encoder engines outside deliver event pulses and
  the timer value; all of them run on CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module mfilt_top
  import mfilt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [7:0]  WB_DAT_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_SEL_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [7:0]  WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire mfilt_pins_s PINS_I,
  output mfilt_pins_s      FILT_O,
  input  wire logic        SLEEP_I,
  input  wire logic [2:0]  CAP_EVENT_I,
  input  wire logic [2:0]  CAP_IRQ_CFG_I,
  input  wire logic        VEL_UPDATE_I,
  input  wire logic        POS_EVENT_I,
  input  wire logic        DIR_CHANGE_I,
  input  wire logic [7:0]  TIMER_I,
  output logic      [7:0]  CAP_BUF_O,
  output logic             PRESCALE_TICK_O,
  output logic             ENC_RUN_O,
  output logic             WAKE_O,
  output logic             IRQ_O
);
  logic [7:0] ctrl_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] ien_q;
  logic [7:0] prio_q;
  logic       enc_mode_q;
  logic       ack_q;
  logic [7:0] rdat_q;
  logic [6:0] div_cnt_q;
  logic       strobe_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] filt_q;
  logic [1:0] cnt_q [4];
  logic [3:0] out_q;
  logic       slept_q;
  logic [7:0] capbuf_q;
  logic       wake_q;
  logic       irq_q;
  logic       enc_run_q;
  logic       pre_q;
  mfilt_ctrl_s ctrl;

  assign ctrl = mfilt_ctrl_s'(ctrl_q[6:0]);

  wire       req      = WB_CYC_I & WB_STB_I & ~ack_q;
  wire       wr       = req & WB_WE_I & WB_SEL_I;
  wire       wr_ctrl  = wr && (WB_ADR_I == ADR_FILTER_CTRL);
  wire       wr_ien   = wr && (WB_ADR_I == ADR_IRQ_ENABLE);
  wire       wr_clr   = wr && (WB_ADR_I == ADR_IRQ_CLEAR);
  wire       wr_prio  = wr && (WB_ADR_I == ADR_IRQ_PRIO);
  wire       wr_mode  = wr && (WB_ADR_I == ADR_MODE);
  wire [3:0] en_vec   = ctrl_q[EN_LSB +: 4];
  wire [2:0] div_sel  = ctrl.filter_sample_divider;

  logic [7:0] rd_mux;
  always_comb
  begin
    if (WB_ADR_I == ADR_FILTER_CTRL)
      rd_mux = ctrl_q & FILTER_CTRL_MSK;
    else if (WB_ADR_I == ADR_IRQ_FLAGS)
      rd_mux = flags_q;
    else if (WB_ADR_I == ADR_IRQ_ENABLE)
      rd_mux = ien_q;
    else if (WB_ADR_I == ADR_IRQ_PRIO)
      rd_mux = prio_q;
    else if (WB_ADR_I == ADR_MODE)
      rd_mux = {7'h00, enc_mode_q};
    else
      rd_mux = 8'h00;
  end

  // Divider limit: ratio minus one; the unused code behaves as 1:1.
  logic [6:0] div_lim;
  always_comb
  begin
    case (div_sel)
      3'h0:    div_lim = DIV_LIM_1;
      3'h1:    div_lim = DIV_LIM_2;
      3'h2:    div_lim = DIV_LIM_4;
      3'h3:    div_lim = DIV_LIM_16;
      3'h4:    div_lim = DIV_LIM_32;
      3'h5:    div_lim = DIV_LIM_64;
      3'h6:    div_lim = DIV_LIM_128;
      default: div_lim = DIV_LIM_1;
    endcase
  end
  wire div_hit = (div_cnt_q >= div_lim);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      div_cnt_q <= 7'h00;
      strobe_q  <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_hit ? 7'h00 : div_cnt_q + 7'h01;
      strobe_q  <= div_hit;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= PINS_I;
      sync2_q <= sync1_q;
    end
  end

  // One filter per input; a spike seen on fewer than three sample ticks never passes.
  for (genvar i = 0; i < 4; i++)
  begin : g_filt
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        filt_q[i] <= 1'b0;
        cnt_q[i]  <= 2'h0;
      end
      else if (strobe_q)
      begin
        if (sync2_q[i] == filt_q[i])
          cnt_q[i] <= 2'h0;
        else if (cnt_q[i] == STABLE_TICKS - 2'h1)
        begin
          filt_q[i] <= sync2_q[i];
          cnt_q[i]  <= 2'h0;
        end
        else
          cnt_q[i] <= cnt_q[i] + 2'h1;
      end
    end
    // Route applies in capture and encoder modes alike.
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
        out_q[i] <= 1'b0;
      else
        out_q[i] <= en_vec[i] ? filt_q[i] : sync2_q[i];
    end
  end

  // Shared flags: meaning depends on the active mode.
  logic [2:0] ev;
  always_comb
  begin
    if (enc_mode_q)
      ev = SLEEP_I ? 3'h0 : {DIR_CHANGE_I, POS_EVENT_I, VEL_UPDATE_I};
    else
      ev = CAP_EVENT_I & CAP_IRQ_CFG_I;
  end
  // A set in the same cycle as a clear wins. Position flag clears only by software.
  assign flags_d = ((flags_q & ~({8{wr_clr}} & WB_DAT_I)) | {5'h00, ev}) & IRQ_MSK;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_q     <= FILTER_CTRL_RST;
      flags_q    <= IRQ_RST;
      ien_q      <= IRQ_RST;
      prio_q     <= IRQ_RST;
      enc_mode_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= WB_DAT_I & FILTER_CTRL_MSK;
      if (wr_ien)
        ien_q <= WB_DAT_I & IRQ_MSK;
      if (wr_prio)
        prio_q <= WB_DAT_I & IRQ_MSK;
      if (wr_mode)
        enc_mode_q <= WB_DAT_I[0];
      flags_q <= flags_d;
    end
  end

  // Sleep: capture buffer reloads from the timer on wake, not during sleep.
  wire cap_wake = ~enc_mode_q & |(CAP_EVENT_I & CAP_IRQ_CFG_I & ien_q[2:0]);
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      slept_q   <= 1'b0;
      capbuf_q  <= TIMER_RST;
      wake_q    <= 1'b0;
      irq_q     <= 1'b0;
      enc_run_q <= 1'b0;
      pre_q     <= 1'b0;
      ack_q     <= 1'b0;
      rdat_q    <= 8'h00;
    end
    else
    begin
      slept_q   <= SLEEP_I;
      if (slept_q && !SLEEP_I)
        capbuf_q <= TIMER_I;
      wake_q    <= SLEEP_I & cap_wake;
      irq_q     <= |(flags_d & ien_q);
      enc_run_q <= enc_mode_q & ~SLEEP_I;
      pre_q     <= |CAP_EVENT_I & ~enc_mode_q;
      ack_q     <= req;
      rdat_q    <= rd_mux;
    end
  end

  assign WB_ACK_O        = ack_q;
  assign WB_DAT_O        = rdat_q;
  assign FILT_O          = out_q;
  assign CAP_BUF_O       = capbuf_q;
  assign WAKE_O          = wake_q;
  assign IRQ_O           = irq_q;
  assign ENC_RUN_O       = enc_run_q;
  assign PRESCALE_TICK_O = pre_q;

  // Multi-step checks: the two-flop input path and the wake edge.
  sequence s_sync_in;
    ##2 sync2_q == $past(PINS_I, 2);
  endsequence
  sequence s_wake_edge;
    SLEEP_I ##1 !SLEEP_I;
  endsequence

  a_filter_passes: assert property (@(posedge CLK) disable iff (RST)
    $changed(filt_q[0]) |-> $past(strobe_q))
    else $error("filter output changed without a sample strobe");
  a_strobe_single: assert property (@(posedge CLK) disable iff (RST)
    (strobe_q && div_sel != 3'h0 && div_sel != DIV_UNUSED) |=> !strobe_q)
    else $error("sample strobe longer than one cycle");
  a_bypass_route: assert property (@(posedge CLK) disable iff (RST)
    !en_vec[1] |=> out_q[1] == $past(sync2_q[1]))
    else $error("bypassed input not routed raw");
  a_route_filtered: assert property (@(posedge CLK) disable iff (RST)
    en_vec[2] |=> out_q[2] == $past(filt_q[2]))
    else $error("enabled filter not routed to output");
  a_ctrl_bit7: assert property (@(posedge CLK) disable iff (RST)
    !ctrl_q[7])
    else $error("control bit 7 set");
  a_sync_two: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |-> s_sync_in)
    else $error("input did not pass two synchroniser stages");
  a_cap_flag_set: assert property (@(posedge CLK) disable iff (RST)
    (!enc_mode_q && CAP_EVENT_I[0] && CAP_IRQ_CFG_I[0]) |=> flags_q[0])
    else $error("capture event lost");
  a_set_beats_clear: assert property (@(posedge CLK) disable iff (RST)
    ev != 3'h0 |=> (flags_q[2:0] & $past(ev)) == $past(ev))
    else $error("flag event lost against a clear");
  a_flag_sticky: assert property (@(posedge CLK) disable iff (RST)
    !wr_clr |=> ($past(flags_q) & ~flags_q) == 8'h00)
    else $error("flag dropped without a clear write");
  a_irq_level: assert property (@(posedge CLK) disable iff (RST)
    $stable(ien_q) |-> IRQ_O == |(flags_q & ien_q))
    else $error("interrupt level disagrees with enabled flags");
  a_enc_dir_flag: assert property (@(posedge CLK) disable iff (RST)
    (enc_mode_q && !SLEEP_I && DIR_CHANGE_I) |=> flags_q[FLAG_DIR])
    else $error("direction flag not set");
  a_enc_halt_sleep: assert property (@(posedge CLK) disable iff (RST)
    SLEEP_I |=> !enc_run_q)
    else $error("encoder running in sleep");
  a_enc_sleep_quiet: assert property (@(posedge CLK) disable iff (RST)
    (enc_mode_q && SLEEP_I) |=> (flags_q & ~$past(flags_q)) == 8'h00)
    else $error("encoder flag set during sleep");
  a_prescale_sleep: assert property (@(posedge CLK) disable iff (RST)
    (SLEEP_I && !enc_mode_q && CAP_EVENT_I != 3'h0) |=> PRESCALE_TICK_O)
    else $error("capture event not counted in sleep");
  a_sleep_flag_set: assert property (@(posedge CLK) disable iff (RST)
    (SLEEP_I && !enc_mode_q && CAP_EVENT_I[0] && CAP_IRQ_CFG_I[0]) |=> flags_q[FLAG_VEL])
    else $error("capture event in sleep did not set its flag");
  a_wake_enabled: assert property (@(posedge CLK) disable iff (RST)
    (SLEEP_I && !enc_mode_q && (CAP_EVENT_I & CAP_IRQ_CFG_I & ien_q[2:0]) != 3'h0) |=> WAKE_O)
    else $error("enabled capture event in sleep did not wake");
  a_wake_reload: assert property (@(posedge CLK) disable iff (RST)
    s_wake_edge |=> CAP_BUF_O == $past(TIMER_I))
    else $error("capture buffer not reloaded on wake");
endmodule
`default_nettype wire

// >>> testbench/mifi_enc_model.sv
/*
  Pin model of the encoder and capture inputs.
  Assumes the bench sets the levels; spike inverts all pins per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module mifi_enc_model
  import mfilt_pkg::*;
(
  input  wire logic        clk,
  input  wire mfilt_pins_s lvl,
  input  wire logic        spike,
  output mfilt_pins_s      pins
);
  initial pins = '0;
  // Only short spikes are made; steady noise is not what the filter is for.
  always @(posedge clk)
    pins <= spike ? ~lvl : lvl;
endmodule
`default_nettype wire

// >>> testbench/test_motion_input_filter_irq.sv
/*
  Self-checking bench for the input filters and shared motion flags.
  Assumes mfilt_top on one 125 MHz clock and the pin model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_motion_input_filter_irq;
  import mfilt_pkg::*;
  logic        CLK = 0, RST = 1, we = 0, sel = 1, cyc = 0, stb = 0, slp = 0, spk = 0;
  logic [3:0]  adr = '0;
  logic [7:0]  dat = '0, tmr = '0, rd, q, buf_o, old;
  logic [2:0]  cap = '0, cfg = '0, enc = '0;
  mfilt_pins_s lvl = '0, pins, filt;
  logic        ack, tick, run, wake, irq;
  int          error_cnt = 0, num_checks = 0, n, r, nf = 0, nt = 0, nw = 0;

  mfilt_top mfilt_top_i (.CLK(CLK), .RST(RST), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rd),
    .WB_ACK_O(ack), .PINS_I(pins), .FILT_O(filt), .SLEEP_I(slp), .CAP_EVENT_I(cap),
    .CAP_IRQ_CFG_I(cfg), .VEL_UPDATE_I(enc[2]), .POS_EVENT_I(enc[1]),
    .DIR_CHANGE_I(enc[0]), .TIMER_I(tmr), .CAP_BUF_O(buf_o), .PRESCALE_TICK_O(tick),
    .ENC_RUN_O(run), .WAKE_O(wake), .IRQ_O(irq));
  mifi_enc_model mifi_enc_model_i (.clk(CLK), .lvl(lvl), .spike(spk), .pins(pins));

  always #4 CLK = ~CLK;
  // Event counters let scenarios see pulses without racing the clock edge.
  always @(posedge CLK)
  begin
    nt += (tick === 1'b1);
    nw += (wake === 1'b1);
    nf += (filt !== lvl);
  end

  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // Waits for the answer however long it takes; only the watchdog ends a hang.
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    {adr, we, dat, cyc, stb} <= {a, w, d, 2'b11};
    do
      @(posedge CLK);
    while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
    @(posedge CLK);
  endtask

  task automatic rdchk(input string s, input logic [3:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(s, q, e);
  endtask

  task automatic pulse(input logic [2:0] c, input logic [2:0] e);
    {cap, enc} <= {c, e};
    @(posedge CLK);
    {cap, enc} <= 6'h00;
    repeat (4) @(posedge CLK);
  endtask

  function automatic int ratio(input int c);
    return (c == 7) ? 1 : (c < 3) ? (1 << c) : (1 << (c + 1));
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    error_cnt++;
    stop_test;
  end

  initial
  begin
    n = $urandom(3);
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rdchk("ctrl_rst", ADR_FILTER_CTRL, FILTER_CTRL_RST);
    rdchk("flag_rst", ADR_IRQ_FLAGS, IRQ_RST);
    wb(ADR_FILTER_CTRL, 1'b1, 8'hff);
    rdchk("ctrl_bits", ADR_FILTER_CTRL, 8'h7f);
    sel <= 1'b0;
    wb(ADR_FILTER_CTRL, 1'b1, 8'h00);
    sel <= 1'b1;
    rdchk("sel_low", ADR_FILTER_CTRL, 8'h7f);
    wb(4'h2, 1'b1, 8'h55);
    rdchk("unmapped", 4'h2, 8'h00);
    $display("test registers done");
    wb(ADR_FILTER_CTRL, 1'b1, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      lvl <= 4'($urandom);
      repeat (6) @(posedge CLK);
      chk("bypass", {4'h0, filt}, {4'h0, lvl});
    end
    lvl <= '0;
    repeat (8) @(posedge CLK);
    n = nf;
    spk <= 1'b1;
    @(posedge CLK);
    spk <= 1'b0;
    repeat (8) @(posedge CLK);
    chk("raw_spike", 8'(nf - n), 8'h01);
    wb(ADR_FILTER_CTRL, 1'b1, 8'h78);
    repeat (8) @(posedge CLK);
    n = nf;
    spk <= 1'b1;
    repeat (2) @(posedge CLK);
    spk <= 1'b0;
    repeat (12) @(posedge CLK);
    chk("spike_kept", 8'(nf - n), 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wb(ADR_FILTER_CTRL, 1'b1, 8'h08 | 8'(c));
      r = ratio(c);
      lvl.encoder_index_input <= ~lvl.encoder_index_input;
      n = 0;
      do
      begin
        @(posedge CLK);
        n++;
      end
      while (filt.encoder_index_input !== lvl.encoder_index_input && n < 1000);
      chk("latency", 8'(n >= 2 * r + 2 && n <= 3 * r + 6), 8'h01);
    end
    $display("test filters done");
    wb(ADR_IRQ_ENABLE, 1'b1, 8'h00);
    for (int ch = 0; ch < 3; ch++)
    begin
      cfg <= 3'(1 << ch);
      pulse(3'h7, 3'h0);
      rdchk("cap_flag", ADR_IRQ_FLAGS, 8'(1 << ch));
      chk("irq_masked", {7'h0, irq}, 8'h00);
      wb(ADR_IRQ_CLEAR, 1'b1, 8'h07);
    end
    cfg <= 3'h7;
    wb(ADR_IRQ_ENABLE, 1'b1, 8'h02);
    rdchk("ien", ADR_IRQ_ENABLE, 8'h02);
    pulse(3'h2, 3'h0);
    chk("irq_on", {7'h0, irq}, 8'h01);
    wb(ADR_IRQ_CLEAR, 1'b1, 8'h02);
    repeat (2) @(posedge CLK);
    chk("irq_off", {7'h0, irq}, 8'h00);
    wb(ADR_MODE, 1'b1, 8'h01);
    rdchk("mode", ADR_MODE, 8'h01);
    wb(ADR_FILTER_CTRL, 1'b1, 8'h78);
    repeat (8) @(posedge CLK);
    n = nf;
    spk <= 1'b1;
    repeat (2) @(posedge CLK);
    spk <= 1'b0;
    repeat (12) @(posedge CLK);
    chk("enc_spike", 8'(nf - n), 8'h00);
    for (int e = 0; e < 3; e++)
    begin
      pulse(3'h0, 3'(4 >> e));
      rdchk("enc_flag", ADR_IRQ_FLAGS, 8'(1 << e));
      wb(ADR_IRQ_CLEAR, 1'b1, 8'h07);
    end
    chk("enc_run", {7'h0, run}, 8'h01);
    slp <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("enc_halt", {7'h0, run}, 8'h00);
    pulse(3'h0, 3'h7);
    rdchk("enc_sleep", ADR_IRQ_FLAGS, 8'h00);
    $display("test flags done");
    wb(ADR_MODE, 1'b1, 8'h00);
    wb(ADR_IRQ_ENABLE, 1'b1, 8'h01);
    old = buf_o;
    tmr <= ~old;
    n = nt;
    r = nw;
    pulse(3'h1, 3'h0);
    chk("sleep_tick", 8'(nt - n), 8'h01);
    chk("sleep_nocap", buf_o, old);
    chk("wake", 8'(nw > r), 8'h01);
    rdchk("sleep_flag", ADR_IRQ_FLAGS, 8'h01);
    slp <= 1'b0;
    repeat (4) @(posedge CLK);
    chk("wake_buf", buf_o, ~old);
    $display("test sleep done");
    stop_test;
  end
endmodule
`default_nettype wire
